// ==== hw/adc_seq_map.svh ====
// constants for the converter sequencer: rates, timing counts, channel codes, modes
// assumes a 10 MHz system clock that also clocks the converter control
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

`define CLK_SYS_HZ 10000000
`define RATE_1M_HZ 1000000
`define RATE_500K_HZ 500000
`define RATE_250K_HZ 250000
`define RATE_200K_HZ 200000
`define RATE_125K_HZ 125000
`define RATE_100K_HZ 100000
`define RATE_50K_HZ 50000
`define RATE_25K_HZ 25000
`define TEMP_MAX_HZ 50000
`define TEMP_RATE_DIV 10
`define CAL_CYCLES 6
`define AVG_DEPTH 64
`define AVG_SHIFT 6
`define FIFO_WORDS 8

`define RATE_SEL_1M 3'h0
`define RATE_SEL_500K 3'h1
`define RATE_SEL_250K 3'h2
`define RATE_SEL_200K 3'h3
`define RATE_SEL_125K 3'h4
`define RATE_SEL_100K 3'h5
`define RATE_SEL_50K 3'h6
`define RATE_SEL_25K 3'h7

`define CH_TEMPERATURE_DIODE 5'h11
`define CH_NULL 5'h1F

`define MODE_STOP 2'h0
`define MODE_CONTINUOUS 2'h1
`define MODE_BLOCK 2'h2

`define WORD_AVG_VALID_BIT 31
`define WORD_TEMP_BIT 30
`define WORD_SLOT_LSB 24
`define WORD_SECOND_LSB 12
`define WORD_FIRST_LSB 0

`endif

// ==== hw/adc_seq_pkg.sv ====
// types shared by the converter sequencer
// assumes adc_seq_map.svh for the numeric constants
package adc_seq_pkg;
	typedef enum logic [4:0] {
		st_idle = 5'h01,
		st_cal = 5'h02,
		st_wait = 5'h04,
		st_busy = 5'h08,
		st_store = 5'h10
	} seq_state_t;
endpackage : adc_seq_pkg

// ==== hw/adc_sequencer.sv ====
// sequencer and converter control with diode mode handling and sample storage
// assumes the converter control runs on clk_sys and answers each start with one done pulse
// How it works
// RULE1: diode conversions run at no more than 50 kilosamples per second.
// RULE2: after a diode slot, a normal slot returns the converter to normal rate.
// RULE3: each mode change runs a calibration of six ticks at the new rate.
// RULE4: diode result is the mean of the latest 64 samples, sliding per sample.
// RULE5: only the first converter may select the temperature diode.
// RULE6: diode rate is 50 kHz for 1M/500k, else one tenth of converter rate.
// RULE7: list holds up to 64 slots, each naming a channel or the diode.
// RULE8: a channel may repeat across slots to be converted more often.
// RULE9: slot list is fixed by parameters; conversion mode changes at run time.
// RULE10: both converters share one list length and advance slots together.
// RULE11: each converter has its own independently set channel list.
// RULE12: empty second-converter slot does a dummy conversion reporting zero.
// RULE13: a diode slot on the first converter empties the same second slot.
// RULE14: both converters start on the same cycle for simultaneous sampling.
// RULE15: separate single controllers are asynchronous; no alignment is promised.
// RULE16: per-channel high and low limits raise a violation pulse when crossed.
// RULE17: block mode stores one full round per request, then stops.
// RULE18: host drains the stored block before requesting the next one.
// RULE19: a round-done pulse optionally marks each completely stored round.
// RULE20: the host writes and reads back the conversion mode command.
// RULE21: reset returns to slot zero, idle, with averaging history cleared.
`include "adc_seq_map.svh"
`timescale 1ns/1ps
module adc_sequencer #(
	parameter int SLOT_COUNT = 64,
	parameter bit DUAL = 1'b1,
	parameter bit ROUND_NOTIFY = 1'b1,
	parameter logic [64*5-1:0] FIRST_SLOTS = {64{5'h01}},
	parameter logic [64*5-1:0] SECOND_SLOTS = {64{5'h01}},
	parameter logic [32*12-1:0] THR_HIGH = {32{12'hFFF}},
	parameter logic [32*12-1:0] THR_LOW = {32{12'h000}},
	parameter int FIFO_DEPTH = `FIFO_WORDS
) (
	input wire logic clk_sys, // system clock, 10 MHz
	input wire logic rstn, // async reset, active low
	input wire logic [2:0] rate_sel, // configured converter rate
	input wire logic cmd_wr, // write strobe for the mode command
	input wire logic [1:0] cmd_wdata, // mode command value
	output logic [1:0] cmd_rdata, // mode command readback
	input wire logic block_req, // request one stored round
	output logic first_start, // start pulse, first converter
	output logic [4:0] first_channel, // channel, first converter
	input wire logic first_done, // conversion done, first converter
	input wire logic [11:0] first_data, // result, first converter
	output logic second_start, // start pulse, second converter
	output logic [4:0] second_channel, // channel, second converter
	input wire logic second_done, // conversion done, second converter
	input wire logic [11:0] second_data, // result, second converter
	output logic temp_mode, // converter in diode sensing mode
	output logic cal_start, // calibration start pulse
	output logic cal_busy, // calibration in progress
	output logic sample_tick, // sampling rate enable pulse
	output logic round_done, // pulse after the last slot of a round is stored
	output logic thr_first_violation, // limit crossed, first converter
	output logic thr_second_violation, // limit crossed, second converter
	output logic [4:0] thr_channel, // channel of the violation
	output logic out_valid, // stored word available
	input wire logic out_ready, // host takes the word
	output logic [31:0] out_data // stored word
);
	localparam int SLOT_W = 6;
	adc_seq_pkg::seq_state_t state;
	logic [SLOT_W-1:0] slot;
	logic [11:0] tick_count;
	logic tick_reload;
	logic [2:0] cal_count;
	logic block_pending;
	logic first_got;
	logic second_got;
	logic [11:0] first_result;
	logic [11:0] second_result;
	logic fifo_in_ready;
	logic fifo_push;
	logic [31:0] fifo_word;
	logic avg_in;
	logic [11:0] avg_mean;
	logic avg_valid;
	logic go;
	logic [4:0] slot_first;
	logic [4:0] slot_second;
	logic need_temp;
	logic next_first_got;
	logic next_second_got;

	// cycles of clk_sys per sample for the selected rate and mode
	function automatic logic [11:0] period_cycles(input logic [2:0] sel, input logic temp);
		logic [11:0] normal;
		normal = 12'h000;
		case (sel)
			`RATE_SEL_1M: normal = 12'(`CLK_SYS_HZ / `RATE_1M_HZ);
			`RATE_SEL_500K: normal = 12'(`CLK_SYS_HZ / `RATE_500K_HZ);
			`RATE_SEL_250K: normal = 12'(`CLK_SYS_HZ / `RATE_250K_HZ);
			`RATE_SEL_200K: normal = 12'(`CLK_SYS_HZ / `RATE_200K_HZ);
			`RATE_SEL_125K: normal = 12'(`CLK_SYS_HZ / `RATE_125K_HZ);
			`RATE_SEL_100K: normal = 12'(`CLK_SYS_HZ / `RATE_100K_HZ);
			`RATE_SEL_50K: normal = 12'(`CLK_SYS_HZ / `RATE_50K_HZ);
			default: normal = 12'(`CLK_SYS_HZ / `RATE_25K_HZ);
		endcase
		if (!temp)
			return normal;
		if (sel == `RATE_SEL_1M || sel == `RATE_SEL_500K)
			return 12'(`CLK_SYS_HZ / `TEMP_MAX_HZ); // see RULE1
		return 12'(32'(normal) * `TEMP_RATE_DIV); // see RULE6
	endfunction : period_cycles

	// channel of a slot; the diode is never allowed on the second converter
	function automatic logic [4:0] second_of(input logic [SLOT_W-1:0] s);
		logic [4:0] a;
		logic [4:0] b;
		a = FIRST_SLOTS[s*5 +: 5];
		b = SECOND_SLOTS[s*5 +: 5];
		if (a == `CH_TEMPERATURE_DIODE) // see RULE13
			return `CH_NULL;
		if (b == `CH_TEMPERATURE_DIODE) // see RULE5
			return `CH_NULL;
		return b;
	endfunction : second_of

	function automatic logic limit_hit(input logic [4:0] ch, input logic [11:0] v);
		return (v > THR_HIGH[ch*12 +: 12]) || (v < THR_LOW[ch*12 +: 12]); // see RULE16
	endfunction : limit_hit

	// slot tables come from parameters only; both share one length and one index
	assign slot_first = FIRST_SLOTS[slot*5 +: 5]; // see RULE7, RULE8, RULE9, RULE11
	assign slot_second = second_of(slot); // see RULE10
	assign need_temp = (slot_first == `CH_TEMPERATURE_DIODE);
	assign go = (cmd_rdata == `MODE_CONTINUOUS) ||
		((cmd_rdata == `MODE_BLOCK) && block_pending);
	assign next_first_got = first_got || first_done;
	assign next_second_got = second_got || second_done || !DUAL; // see RULE15
	assign tick_reload = (state == adc_seq_pkg::st_idle) && go && (need_temp != temp_mode);
	assign sample_tick = (tick_count == 12'h000) && !tick_reload;
	assign cal_busy = (state == adc_seq_pkg::st_cal);
	assign avg_in = (state == adc_seq_pkg::st_busy) && next_first_got && next_second_got &&
		need_temp;

	// mode command, changeable while running
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			cmd_rdata <= `MODE_STOP;
		else if (cmd_wr)
			cmd_rdata <= cmd_wdata; // see RULE9, RULE20

	// block request stays pending until its round is stored; a new request wins
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			block_pending <= 1'b0;
		else if (block_req)
			block_pending <= 1'b1; // see RULE18
		else if (state == adc_seq_pkg::st_store && slot == SLOT_W'(SLOT_COUNT - 1) &&
			cmd_rdata == `MODE_BLOCK)
			block_pending <= 1'b0; // see RULE17

	// sample rate divider, restarted on a mode switch so ticks follow the new rate
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			tick_count <= 12'h000;
		else if (tick_reload)
			tick_count <= period_cycles(rate_sel, need_temp) - 12'h001; // see RULE3
		else if (tick_count == 12'h000)
			tick_count <= period_cycles(rate_sel, temp_mode) - 12'h001;
		else
			tick_count <= tick_count - 12'h001;

	// slot walk and conversion control
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			state <= adc_seq_pkg::st_idle; // see RULE21
			slot <= '0;
			temp_mode <= 1'b0;
			cal_count <= 3'h0;
		end
		else
		begin
			case (state)
				adc_seq_pkg::st_idle:
				begin
					if (go && need_temp != temp_mode)
					begin
						temp_mode <= need_temp; // see RULE2
						cal_count <= 3'h0;
						state <= adc_seq_pkg::st_cal;
					end
					else if (go)
						state <= adc_seq_pkg::st_wait;
				end
				adc_seq_pkg::st_cal:
				begin
					if (sample_tick)
					begin
						cal_count <= cal_count + 3'h1;
						if (cal_count == 3'(`CAL_CYCLES - 1))
							state <= adc_seq_pkg::st_wait; // see RULE3
					end
				end
				adc_seq_pkg::st_wait:
				begin
					if (!go)
						state <= adc_seq_pkg::st_idle;
					else if (sample_tick && fifo_in_ready)
						state <= adc_seq_pkg::st_busy;
				end
				adc_seq_pkg::st_busy:
				begin
					if (next_first_got && next_second_got)
						state <= adc_seq_pkg::st_store;
				end
				adc_seq_pkg::st_store:
				begin
					if (slot == SLOT_W'(SLOT_COUNT - 1))
						slot <= '0;
					else
						slot <= slot + 1'b1;
					state <= adc_seq_pkg::st_idle;
				end
				default: state <= adc_seq_pkg::st_idle;
			endcase
		end

	// start pulses and channels; both converters start on the same edge
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			first_start <= 1'b0;
			second_start <= 1'b0;
			first_channel <= 5'h00;
			second_channel <= `CH_NULL;
			cal_start <= 1'b0;
		end
		else
		begin
			first_start <= (state == adc_seq_pkg::st_wait) && go && sample_tick &&
				fifo_in_ready; // see RULE14
			second_start <= DUAL && (state == adc_seq_pkg::st_wait) && go && sample_tick &&
				fifo_in_ready; // see RULE12
			cal_start <= tick_reload; // see RULE3
			if (state == adc_seq_pkg::st_wait)
			begin
				first_channel <= slot_first;
				second_channel <= slot_second;
			end
		end

	// results; an empty second slot reports zero whatever the converter returns
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			first_got <= 1'b0;
			second_got <= 1'b0;
			first_result <= 12'h000;
			second_result <= 12'h000;
		end
		else if (state == adc_seq_pkg::st_busy)
		begin
			first_got <= next_first_got;
			second_got <= next_second_got;
			if (first_done && !first_got)
				first_result <= first_data;
			if (second_done && !second_got)
				second_result <= (slot_second == `CH_NULL) ? 12'h000 : second_data; // see RULE12
		end
		else
		begin
			first_got <= 1'b0;
			second_got <= 1'b0;
		end

	// diode samples feed the averager; its mean is ready in the store cycle
	temp_average #(
		.DEPTH(`AVG_DEPTH),
		.SHIFT(`AVG_SHIFT)
	) u_avg (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.sample_valid(avg_in),
		.sample(first_done && !first_got ? first_data : first_result),
		.mean(avg_mean),
		.mean_valid(avg_valid)
	);

	assign fifo_push = (state == adc_seq_pkg::st_store);
	always_comb
	begin
		fifo_word = 32'h0000_0000;
		fifo_word[`WORD_AVG_VALID_BIT] = need_temp && avg_valid;
		fifo_word[`WORD_TEMP_BIT] = need_temp;
		fifo_word[`WORD_SLOT_LSB +: SLOT_W] = slot;
		fifo_word[`WORD_SECOND_LSB +: 12] = DUAL ? second_result : 12'h000;
		fifo_word[`WORD_FIRST_LSB +: 12] = need_temp ? avg_mean : first_result; // see RULE4
	end

	// room is checked before each start, so a push never meets a full fifo
	sample_fifo #(
		.WIDTH(32),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(fifo_word),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_data)
	);

	// limit checks and round notification at store time
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			thr_first_violation <= 1'b0;
			thr_second_violation <= 1'b0;
			thr_channel <= 5'h00;
			round_done <= 1'b0;
		end
		else
		begin
			thr_first_violation <= fifo_push && !need_temp &&
				limit_hit(slot_first, first_result); // see RULE16
			thr_second_violation <= fifo_push && DUAL && slot_second != `CH_NULL &&
				limit_hit(slot_second, second_result); // see RULE16
			if (fifo_push)
				thr_channel <= (!need_temp && limit_hit(slot_first, first_result)) ?
					slot_first : slot_second;
			round_done <= ROUND_NOTIFY && fifo_push &&
				slot == SLOT_W'(SLOT_COUNT - 1); // see RULE19
		end
endmodule : adc_sequencer

// ==== hw/sample_fifo.sv ====
// sample fifo with valid/ready on both sides
// assumes one clock; full and empty come from an occupancy count
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic in_valid, // word offered
	output logic in_ready, // room for a word
	input wire logic [WIDTH-1:0] in_data, // word in
	output logic out_valid, // word available
	input wire logic out_ready, // consumer takes word
	output logic [WIDTH-1:0] out_data // oldest word
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic do_wr;
	logic do_rd;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		if (p == AW'(DEPTH - 1))
			return '0;
		return p + 1'b1;
	endfunction : bump

	assign in_ready = (count != (AW + 1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= '0;
		end
		else if (do_wr)
			mem[wr_ptr] <= in_data;

	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (do_wr)
				wr_ptr <= bump(wr_ptr);
			if (do_rd)
				rd_ptr <= bump(rd_ptr);
			if (do_wr && !do_rd)
				count <= count + 1'b1;
			else if (do_rd && !do_wr)
				count <= count - 1'b1;
		end
endmodule : sample_fifo

// ==== hw/temp_average.sv ====
// sliding-window mean over the latest diode samples
// assumes sample_valid pulses once per diode conversion
`include "adc_seq_map.svh"
`timescale 1ns/1ps
module temp_average #(
	parameter int DEPTH = `AVG_DEPTH,
	parameter int SHIFT = `AVG_SHIFT
) (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic sample_valid, // new diode sample
	input wire logic [11:0] sample, // diode code
	output logic [11:0] mean, // window mean, one cycle after sample
	output logic mean_valid // window completely filled
);
	localparam int SW = 12 + SHIFT;
	localparam int PW = $clog2(DEPTH);
	logic [11:0] hist [DEPTH];
	logic [PW-1:0] ptr;
	logic [PW:0] fill;
	logic [SW-1:0] sum;
	logic [SW-1:0] next_sum;

	// history starts at zero, so the oldest slot adds nothing until it is filled
	assign next_sum = sum + SW'(sample) - SW'(hist[ptr]); // see RULE4

	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			for (int i = 0; i < DEPTH; i++)
				hist[i] <= '0; // see RULE21
			ptr <= '0;
			fill <= '0;
			sum <= '0;
			mean <= '0;
			mean_valid <= 1'b0;
		end
		else if (sample_valid)
		begin
			hist[ptr] <= sample;
			ptr <= ptr + 1'b1;
			sum <= next_sum;
			mean <= next_sum[SW-1:SHIFT]; // see RULE4
			if (fill != (PW + 1)'(DEPTH))
				fill <= fill + 1'b1;
			mean_valid <= (fill >= (PW + 1)'(DEPTH - 1));
		end
endmodule : temp_average

// ==== verification/adc_sequencer_checker.sv ====
// checker for the sequencer top: slot, mode, calibration and storage relations
// assumes a dual build and that it is bound to every adc_sequencer instance
`include "adc_seq_map.svh"
`timescale 1ns/1ps
module adc_sequencer_checker (
	input wire logic clk_sys, // clock
	input wire logic rstn, // reset, active low
	input wire logic [2:0] rate_sel, // rate
	input wire logic cmd_wr, // mode write
	input wire logic [1:0] cmd_wdata, // mode in
	input wire logic [1:0] cmd_rdata, // mode out
	input wire logic first_start, // start one
	input wire logic [4:0] first_channel, // channel one
	input wire logic second_start, // start two
	input wire logic [4:0] second_channel, // channel two
	input wire logic temp_mode, // diode mode
	input wire logic cal_busy, // calibrating
	input wire logic sample_tick, // rate tick
	input wire logic round_done, // round stored
	input wire logic thr_first_violation, // limit hit
	input wire logic out_valid, // word ready
	input wire logic out_ready, // word taken
	input wire logic [31:0] out_data // word
);
	logic [15:0] gap;
	logic [3:0] cal_ticks;
	function automatic int temp_period(input logic [2:0] r);
		case (r)
			3'h0, 3'h1: return 200;
			3'h2: return 400;
			3'h3: return 500;
			3'h4: return 800;
			3'h5: return 1000;
			3'h6: return 2000;
			default: return 4000;
		endcase
	endfunction : temp_period
	// cycles since the last start, saturating
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			gap <= 16'hFFFF;
		else if (first_start)
			gap <= 16'h0000;
		else if (gap != 16'hFFFF)
			gap <= gap + 16'h0001;
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			cal_ticks <= 4'h0;
		else if (!cal_busy)
			cal_ticks <= 4'h0;
		else if (sample_tick)
			cal_ticks <= cal_ticks + 4'h1;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_no_diode_second; second_start |-> second_channel != `CH_TEMPERATURE_DIODE; endproperty
	a_no_diode_second: assert property (p_no_diode_second) else $error("diode on second");
	property p_diode_empties; first_start && first_channel == `CH_TEMPERATURE_DIODE
		|-> second_channel == `CH_NULL; endproperty
	a_diode_empties: assert property (p_diode_empties) else $error("diode slot not empty");
	property p_lockstep; first_start == second_start; endproperty
	a_lockstep: assert property (p_lockstep) else $error("starts not aligned");
	property p_mode_follows; first_start |-> temp_mode == (first_channel == `CH_TEMPERATURE_DIODE);
	endproperty
	a_mode_follows: assert property (p_mode_follows) else $error("wrong converter mode");
	property p_cal_six; $fell(cal_busy) |-> cal_ticks == 4'h6; endproperty
	a_cal_six: assert property (p_cal_six) else $error("calibration tick count");
	property p_diode_rate; first_start && temp_mode |-> gap >= temp_period(rate_sel) - 1; endproperty
	a_diode_rate: assert property (p_diode_rate) else $error("diode rate too fast");
	property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
	a_hold: assert property (p_hold) else $error("stored word lost");
	property p_readback; cmd_wr |=> cmd_rdata == $past(cmd_wdata); endproperty
	a_readback: assert property (p_readback) else $error("mode readback");
	property p_reset; disable iff (1'b0) !rstn |-> second_channel == `CH_NULL && !out_valid
		&& cmd_rdata == `MODE_STOP && !temp_mode; endproperty
	a_reset: assert property (p_reset) else $error("reset state");
	c_cal: cover property ($fell(cal_busy));
	c_round: cover property (round_done);
	c_thr: cover property (thr_first_violation);
endmodule : adc_sequencer_checker

bind adc_sequencer adc_sequencer_checker u_checker (.*);

// ==== verification/host_reader.sv ====
// host side model: drains stored words into a queue, can be told to stall
// assumes the bench reads the queue by hierarchy
`timescale 1ns/1ps
module host_reader (
	input wire logic clk_sys, // clock
	input wire logic stall, // hold off reads
	input wire logic out_valid, // word offered
	input wire logic [31:0] out_data, // word
	output logic out_ready // word taken
);
	logic [31:0] q[$];
	initial out_ready = 1'b0;
	always @(negedge clk_sys)
		out_ready <= !stall;
	always @(posedge clk_sys)
		if (out_valid && out_ready)
			q.push_back(out_data);
endmodule : host_reader

// ==== verification/tb_adc_sequencer_temp_sensing.sv ====
// bench for the sequencer: block rounds at two rates, fifo fill and drain
// assumes four slots, diode on slot 1, converter answers three cycles after start
`include "adc_seq_map.svh"
`timescale 1ns/1ps
module tb_adc_sequencer_temp_sensing;
	logic clk_sys = 1'b0, rstn = 1'b1, cmd_wr = 1'b0, block_req = 1'b0, stall = 1'b0;
	logic [2:0] rate_sel = 3'h0;
	logic [1:0] cmd_wdata = 2'h0, cmd_rdata;
	logic first_start, second_start, first_done = 1'b0, second_done = 1'b0;
	logic [4:0] first_channel, second_channel, thr_channel;
	logic [11:0] first_data = 12'h000, second_data = 12'h000;
	logic temp_mode, cal_start, cal_busy, sample_tick, round_done;
	logic thr_first_violation, thr_second_violation, out_valid, out_ready;
	logic [31:0] out_data;
	logic [1:0] cnv = 2'h0;
	int n_mismatch = 0, n_checks = 0, n_starts = 0, n_diode = 0, cycles = 0;
	int n_thr = 0, n_thr2 = 0, n_round = 0, n_cal = 0;
	localparam logic [11:0] EXP_FIRST[4] = '{12'h102, 12'h000, 12'h102, 12'h103};
	localparam logic [11:0] EXP_SECOND[4] = '{12'h204, 12'h000, 12'h205, 12'h000};
	always #50 clk_sys = ~clk_sys;
	adc_sequencer #(
		.SLOT_COUNT(4),
		.FIRST_SLOTS({{60{5'h01}}, 5'h03, 5'h02, 5'h11, 5'h02}),
		.SECOND_SLOTS({{60{5'h01}}, 5'h1F, 5'h05, 5'h1F, 5'h04}),
		.THR_HIGH({{29{12'hFFF}}, 12'h101, {2{12'hFFF}}}),
		.THR_LOW({{26{12'h000}}, 12'h206, {5{12'h000}}})
	) u_dut (.*);
	host_reader u_host (.clk_sys(clk_sys), .stall(stall), .out_valid(out_valid),
		.out_data(out_data), .out_ready(out_ready));
	// converter stand-in; data lines toggle while not valid
	always @(negedge clk_sys)
	begin
		first_done <= (cnv == 2'h1);
		second_done <= (cnv == 2'h1);
		first_data <= (cnv != 2'h1) ? ~first_data : (first_channel == `CH_TEMPERATURE_DIODE)
			? 12'h800 : {7'h08, first_channel};
		second_data <= (cnv != 2'h1) ? ~second_data : {7'h10, second_channel};
		cnv <= first_start ? 2'h3 : ((cnv != 2'h0) ? cnv - 2'h1 : 2'h0);
	end
	// registered pulses are counted half a cycle after they launch
	always @(negedge clk_sys)
	begin
		cycles++;
		if (first_start)
			n_starts++;
		if (thr_first_violation && thr_channel == 5'h02)
			n_thr++;
		if (thr_second_violation)
			n_thr2++;
		if (round_done)
			n_round++;
		if (cal_start)
			n_cal++;
		if (cycles == 30000)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: run too long", $time);
			complete_run();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : step
	task automatic set_mode(input logic [1:0] m);
		cmd_wdata = m;
		cmd_wr = 1'b1;
		step(1);
		cmd_wr = 1'b0;
		step(1);
		check(32'(cmd_rdata), 32'(m));
	endtask : set_mode
	task automatic wait_words(input int n);
		for (int i = 0; i < 8000 && u_host.q.size() < n; i++)
			step(1);
	endtask : wait_words
	task automatic check_word(input logic [31:0] w, input int s);
		logic [11:0] f;
		f = EXP_FIRST[s];
		if (s == 1)
		begin
			n_diode++;
			f = 12'((n_diode * 2048) >> 6);
		end
		check(w, {1'b0, s == 1, 6'(s), EXP_SECOND[s], f});
	endtask : check_word
	task automatic t_block(input logic [2:0] r);
		int base;
		int thr1;
		int thr2;
		int rounds;
		int cals;
		rate_sel = r;
		set_mode(`MODE_BLOCK);
		base = u_host.q.size();
		thr1 = n_thr;
		thr2 = n_thr2;
		rounds = n_round;
		cals = n_cal;
		block_req = 1'b1;
		step(1);
		block_req = 1'b0;
		wait_words(base + 4);
		step(600);
		check(32'(u_host.q.size()), 32'(base + 4));
		for (int s = 0; s < 4; s++)
			check_word(u_host.q[base + s], s);
		check(32'(n_thr - thr1), 32'h2);
		check(32'(n_thr2 - thr2), 32'h1);
		check(32'(n_round - rounds), 32'h1);
		check(32'(n_cal - cals), 32'h2);
		$display("test block at rate %0d done", r);
	endtask : t_block
	task automatic t_fill;
		int base;
		int s0;
		int rounds;
		stall = 1'b1;
		rounds = n_round;
		rate_sel = 3'h0;
		base = u_host.q.size();
		set_mode(`MODE_CONTINUOUS);
		step(6000);
		s0 = n_starts;
		step(400);
		check(32'(n_starts), 32'(s0));
		set_mode(`MODE_STOP);
		stall = 1'b0;
		step(50);
		check(32'(u_host.q.size()), 32'(base + 8));
		for (int i = 0; i < 8; i++)
			check_word(u_host.q[base + i], i % 4);
		check(32'(out_valid), 32'h0);
		check(32'(n_round - rounds), 32'h2);
		$display("test fifo fill and drain done");
	endtask : t_fill
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	initial
	begin
		#1 rstn = 1'b0;
		step(4);
		rstn = 1'b1;
		step(1);
		check(32'({cmd_rdata, second_channel, out_valid, temp_mode}), 32'({2'h0, `CH_NULL, 2'h0}));
		$display("test reset done");
		t_block(3'h0);
		t_block(3'h3);
		t_fill();
		complete_run();
	end
endmodule : tb_adc_sequencer_temp_sensing
